//--- core/dcsr_regs.vh
// Bit positions, reset values and timing counts of the diagnostic control bits.
// Functional notes
// - Ground-LED bit 2 set hides ground-LED flags from channel diagnostic registers.
// - Open-load bit 1 set freezes on/off open-load flags at their last stored values.
// - Writing one to bit 0 clears all user registers; writing zero does nothing.
// - Soft clear also restarts the isolation link transfer.
// - Hardware clears the soft clear bit itself after triggering.
`ifndef DCSR_REGS_VH
`define DCSR_REGS_VH
`define DCSR_BIT_CLEAR      0
`define DCSR_BIT_OL_DIS     1
`define DCSR_BIT_LEDG_DIS   2
`define DCSR_CTRL_RESET     3'h0
`define DCSR_DIAG_RESET     8'h00
`define DCSR_FLAG_LEDG      0
`define DCSR_FLAG_OLA       1
`define DCSR_FLAG_OLI       2
`define DCSR_CLEAR_CYCLES   2'h2
`endif

//--- core/dcsr_diag_reg.v
// One channel diagnostic register with per-bit update enables and a clear.
`timescale 1ns/1ns
`default_nettype none
`include "dcsr_regs.vh"
module dcsr_diag_reg (
   // Clock and reset
   input  wire       i_core_clk,
   input  wire       i_reset_n,
   // Control
   input  wire       i_clear,
   input  wire [7:0] i_update_en,
   input  wire [7:0] i_flags,
   // Stored value
   output reg  [7:0] o_value
);
   genvar b;
   generate
      for (b = 0; b < 8; b = b + 1) begin : g_bit
         always @(posedge i_core_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               o_value[b] <= 1'b0;
            end else if (i_clear) begin
               o_value[b] <= 1'b0;
            end else if (i_update_en[b]) begin
               o_value[b] <= i_flags[b];
            end
         end
      end
   endgenerate
endmodule // dcsr_diag_reg
`default_nettype wire

//--- core/dcsr_top.v
// Diagnostic configuration bits, self-clearing soft clear and channel diagnostic registers.
`timescale 1ns/1ns
`default_nettype none
`include "dcsr_regs.vh"
module dcsr_top (
   // Clock and reset
   input  wire        i_core_clk,
   input  wire        i_reset_n,
   // Control register write port
   input  wire        i_ctrl_wr,
   input  wire [2:0]  i_ctrl_wdata,
   // Raw diagnostics per channel: bit 0 ground-LED, 1 open-load on, 2 open-load off
   input  wire [23:0] i_channel_flags,
   // Control register readback
   output reg  [2:0]  o_ctrl_rdata,
   // Channel diagnostic registers, eight bits per channel
   output wire [63:0] o_channel_diagnostic_regs,
   // Isolation link restart pulse
   output reg         o_isolation_link_transfer_restart
);
   // Soft clear sequencer states.
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_HOLD  = 2'h1;
   localparam [1:0] ST_DONE  = 2'h2;
   localparam [1:0] CNT_ZERO = 2'h0;

   // Configuration bits.
   reg        ground_led_report_disable_q;
   reg        ground_led_report_disable_d;
   reg        open_load_monitor_disable_q;
   reg        open_load_monitor_disable_d;

   // Soft clear sequencer.
   reg        soft_clear_trigger_q;
   reg        soft_clear_trigger_d;
   reg [1:0]  clear_state_q;
   reg [1:0]  clear_state_d;
   reg [1:0]  clear_cnt_q;
   reg [1:0]  clear_cnt_d;

   // Registered pulses and readback.
   reg        diag_clear_q;
   reg        diag_clear_d;
   reg        restart_d;
   reg [2:0]  ctrl_rdata_d;

   // Decoded write strobes.
   reg        clear_start;
   reg        cfg_write;

   // A write with the clear bit set starts a clear; any other write loads configuration.
   always @* begin
      clear_start = i_ctrl_wr & i_ctrl_wdata[`DCSR_BIT_CLEAR];
      cfg_write   = i_ctrl_wr & ~i_ctrl_wdata[`DCSR_BIT_CLEAR];
   end

   always @* begin
      ground_led_report_disable_d = ground_led_report_disable_q;
      open_load_monitor_disable_d = open_load_monitor_disable_q;
      if (clear_start) begin
         // The clear wipes user bits, so configuration returns to defaults.
         ground_led_report_disable_d = 1'b0;
         open_load_monitor_disable_d = 1'b0;
      end else if (cfg_write) begin
         ground_led_report_disable_d = i_ctrl_wdata[`DCSR_BIT_LEDG_DIS];
         open_load_monitor_disable_d = i_ctrl_wdata[`DCSR_BIT_OL_DIS];
      end
   end

   // The trigger bit stays up for the hold count plus one cycle, then drops by itself.
   always @* begin
      clear_state_d        = clear_state_q;
      clear_cnt_d          = clear_cnt_q;
      soft_clear_trigger_d = soft_clear_trigger_q;
      case (clear_state_q)
         ST_IDLE: begin
            soft_clear_trigger_d = 1'b0;
         end
         ST_HOLD: begin
            if (clear_cnt_q != CNT_ZERO) begin
               clear_cnt_d = clear_cnt_q - 2'h1;
            end else begin
               clear_state_d        = ST_DONE;
               soft_clear_trigger_d = 1'b0;
            end
         end
         ST_DONE: begin
            clear_state_d = ST_IDLE;
         end
         default: begin
            clear_state_d        = ST_IDLE;
            soft_clear_trigger_d = 1'b0;
         end
      endcase
      if (clear_start) begin
         clear_state_d        = ST_HOLD;
         clear_cnt_d          = `DCSR_CLEAR_CYCLES;
         soft_clear_trigger_d = 1'b1;
      end
   end

   always @* begin
      diag_clear_d = clear_start;
      restart_d    = clear_start;
      ctrl_rdata_d = `DCSR_CTRL_RESET;
      ctrl_rdata_d[`DCSR_BIT_LEDG_DIS] = ground_led_report_disable_q;
      ctrl_rdata_d[`DCSR_BIT_OL_DIS]   = open_load_monitor_disable_q;
      ctrl_rdata_d[`DCSR_BIT_CLEAR]    = soft_clear_trigger_q;
   end

   // Every register resets to its default asynchronously.
   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ground_led_report_disable_q <= 1'b0;
      end else begin
         ground_led_report_disable_q <= ground_led_report_disable_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         open_load_monitor_disable_q <= 1'b0;
      end else begin
         open_load_monitor_disable_q <= open_load_monitor_disable_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         soft_clear_trigger_q <= 1'b0;
      end else begin
         soft_clear_trigger_q <= soft_clear_trigger_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clear_state_q <= ST_IDLE;
      end else begin
         clear_state_q <= clear_state_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         clear_cnt_q <= CNT_ZERO;
      end else begin
         clear_cnt_q <= clear_cnt_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         diag_clear_q <= 1'b0;
      end else begin
         diag_clear_q <= diag_clear_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_isolation_link_transfer_restart <= 1'b0;
      end else begin
         o_isolation_link_transfer_restart <= restart_d;
      end
   end

   always @(posedge i_core_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ctrl_rdata <= `DCSR_CTRL_RESET;
      end else begin
         o_ctrl_rdata <= ctrl_rdata_d;
      end
   end

   genvar c;

   generate
      for (c = 0; c < 8; c = c + 1) begin : g_ch
         wire       ledg_raw;
         wire       ola_raw;
         wire       oli_raw;
         wire       ledg_shown;
         wire       ola_shown;
         wire       oli_shown;
         wire       ol_update;
         reg  [7:0] upd_en;
         reg  [7:0] flags;

         assign ledg_raw   = i_channel_flags[3*c+`DCSR_FLAG_LEDG];
         assign ola_raw    = i_channel_flags[3*c+`DCSR_FLAG_OLA];
         assign oli_raw    = i_channel_flags[3*c+`DCSR_FLAG_OLI];
         // A hidden ground-LED report reads as zero but keeps updating.
         assign ledg_shown = ledg_raw & ~ground_led_report_disable_q;
         assign ola_shown  = ola_raw & ~open_load_monitor_disable_q;
         assign oli_shown  = oli_raw & ~open_load_monitor_disable_q;
         // Open-load bits freeze while monitoring is off; only a soft clear empties them.
         assign ol_update  = ~open_load_monitor_disable_q;

         always @* begin
            upd_en = 8'h00;
            flags  = 8'h00;
            upd_en[`DCSR_FLAG_LEDG] = 1'b1;
            upd_en[`DCSR_FLAG_OLA]  = ol_update;
            upd_en[`DCSR_FLAG_OLI]  = ol_update;
            flags[`DCSR_FLAG_LEDG]  = ledg_shown;
            flags[`DCSR_FLAG_OLA]   = ola_shown;
            flags[`DCSR_FLAG_OLI]   = oli_shown;
         end

         dcsr_diag_reg u_diag (
            .i_core_clk  (i_core_clk),
            .i_reset_n   (i_reset_n),
            .i_clear     (diag_clear_q),
            .i_update_en (upd_en),
            .i_flags     (flags),
            .o_value     (o_channel_diagnostic_regs[8*c+7:8*c])
         );
      end
   endgenerate
endmodule // dcsr_top
`default_nettype wire

//--- dv/dcsr_asserts.sv
// Checker for the diagnostic control bits.
`timescale 1ns/1ns
`default_nettype none
module dcsr_asserts (
   input wire logic        i_core_clk,
   input wire logic        i_reset_n,
   input wire logic        i_ctrl_wr,
   input wire logic [2:0]  i_ctrl_wdata,
   input wire logic [2:0]  o_ctrl_rdata,
   input wire logic [63:0] o_channel_diagnostic_regs,
   input wire logic        o_isolation_link_transfer_restart
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic        clr = i_ctrl_wr && i_ctrl_wdata[0];
   wire logic        rs  = o_isolation_link_transfer_restart;
   wire logic [63:0] dg  = o_channel_diagnostic_regs;
   a_clear_restart: assert property (clr |=> rs) else $error("no restart");
   a_write_no_clear: assert property (i_ctrl_wr && !i_ctrl_wdata[0] |=> !rs) else $error("restart");
   a_clear_zeroes: assert property (clr |-> ##2 dg == 64'h0) else $error("diag kept");
   a_self_clear_bit: assert property ($rose(o_ctrl_rdata[0]) |-> o_ctrl_rdata[0] [*3] ##1
      !o_ctrl_rdata[0]) else $error("clear bit stuck");
   a_ledg_hidden: assert property (o_ctrl_rdata[2] && $past(o_ctrl_rdata[2]) |->
      (dg & 64'h0101010101010101) == 64'h0) else $error("ground led shown");
   a_ol_frozen: assert property ((o_ctrl_rdata[1] && !rs) [*3] |->
      $stable(dg & 64'h0606060606060606)) else $error("open load moved");
   cover property (clr);
   cover property ($fell(o_ctrl_rdata[0]));
   cover property (o_ctrl_rdata[1] [*3]);
endmodule // dcsr_asserts
bind dcsr_top dcsr_asserts i_dcsr_asserts (.*);
`default_nettype wire

//--- dv/dcsr_host.sv
// Host model that writes the control bits.
`timescale 1ns/1ns
`default_nettype none
module dcsr_host (
   input  wire logic       i_core_clk,
   output var  logic       o_wr = 1'b0,
   output var  logic [2:0] o_wdata = 3'h0
);
   task automatic write(input logic [2:0] d);
      @(posedge i_core_clk) #5;
      o_wr = 1'b1;
      o_wdata = d;
      @(posedge i_core_clk) #5;
      o_wr = 1'b0;
      o_wdata = ~d;
   endtask
endmodule // dcsr_host
`default_nettype wire

//--- dv/tb_top.sv
// Testbench for the diagnostic control bits.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, wr, rs;
   logic [2:0]  wd, rd;
   logic [23:0] fl = 24'hffffff;
   logic [63:0] dg;
   int          failures = 0, check_count = 0, cyc = 0;
   initial forever #50 clk = ~clk;
   dcsr_host i_dcsr_host (.i_core_clk(clk), .o_wr(wr), .o_wdata(wd));
   dcsr_top i_dcsr_top (.i_core_clk(clk), .i_reset_n(rst_n), .i_ctrl_wr(wr), .i_ctrl_wdata(wd),
      .i_channel_flags(fl), .o_ctrl_rdata(rd), .o_channel_diagnostic_regs(dg),
      .o_isolation_link_transfer_restart(rs));
   task automatic chk(string n, logic [63:0] e, logic [63:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wt;
      repeat (3) @(posedge clk);
      #5;
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   always @(posedge clk) if (++cyc > 2000) begin
      failures++;
      summarize();
   end
   task automatic t_ledg;
      i_dcsr_host.write(3'h4);
      wt();
      chk("led off", 64'h0606060606060606, dg);
      i_dcsr_host.write(3'h0);
      chk("restart", 64'h0, rs);
      wt();
      chk("led on", 64'h0707070707070707, dg);
   endtask
   task automatic t_ol;
      i_dcsr_host.write(3'h6);
      wt();
      fl = 24'h0;
      wt();
      chk("ol frozen", 64'h0606060606060606, dg);
      chk("ctrl cfg", 64'h6, rd);
   endtask
   task automatic t_clear;
      i_dcsr_host.write(3'h7);
      chk("restart", 64'h1, rs);
      @(posedge clk) #5;
      chk("cleared", 64'h0, dg);
      chk("ctrl busy", 64'h1, rd);
      wt();
      chk("ctrl", 64'h0, rd);
      fl = 24'hffffff;
      wt();
      chk("ol live", 64'h0707070707070707, dg);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #5 rst_n = 1'b1;
      t_ledg();
      t_ol();
      t_clear();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
